// >>> hdl/mac_control_rx_filter.v
// How it works
// - Each latched event raises the interrupt only while its enable is set.
// - FIFO overflow latches status bit 3.
// - Queue overflow latches status bit 2; reading status clears it.
// - High watermark crossing latches status bit 1; cleared on read.
// - Low watermark crossing latches status bit 0; cleared on read.
// - Bit 6 clear rejects control frames that are not pause frames.
// - Bit 5 clear rejects every control frame.
// - Bit 4 clear rejects frames whose length field mismatches byte count.
// - Bit 3 clear rejects frames with CRC or interface errors.
// - Bit 2 clear rejects dribbling frames that are not collided or runt.
// - Bit 1 clear rejects frames with PHY receive errors.
// - Bit 0 clear rejects broadcast frames.
// - Control bit 28 disables the heartbeat check.
// - Bit 23 blocks reception while transmitting, except in loopback; clear receives own frames.
// - Loopback returns transmit data to receive, nothing goes to the PHY.
// - Bit 20 selects full duplex and disables the heartbeat check.
// - Bit 12 allows retrying late collisions.
// - Bit 10 gives single attempt; else 15 retries, then retry error on the 16th collision.
// - Bit 8 strips pad and FCS from frames under 46 bytes.
// - Bits 7:6 pick 10, 8, 4 or 1 random back-off bits.
// - Transmit only with bit 3 set, receive only with bit 2 set.
// - Watermark is threshold times 32 times 2048 bytes.
// - Bit 5 aborts transmission deferred over 24,288 bit times.
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctl_defs.vh"
module mac_control_rx_filter #(
   parameter DEFER_LIMIT = `DEFER_BIT_TIMES
) (
   input wire clk,
   input wire rst_n,
   input wire [8:0] host_addr,
   input wire host_wr,
   input wire host_rd,
   input wire [7:0] host_wdata,
   output reg [7:0] host_rdata_ff,
   output reg irq_ff,
   input wire fifo_overflow,
   input wire queue_overflow,
   input wire [23:0] queue_level,
   input wire frame_done,
   input wire is_ctrl,
   input wire is_pause,
   input wire len_mismatch,
   input wire crc_err,
   input wire phy_err,
   input wire dribble,
   input wire collided,
   input wire runt,
   input wire broadcast,
   input wire [13:0] frame_len,
   output wire frame_keep,
   output wire frame_drop,
   output wire frame_strip,
   input wire tx_en_in,
   input wire [3:0] txd_in,
   output reg phy_tx_en_ff,
   output reg [3:0] phy_txd_ff,
   input wire phy_rx_dv,
   input wire [3:0] phy_rxd,
   input wire phy_crs,
   output reg rx_dv_ff,
   output reg [3:0] rxd_ff,
   output reg heartbeat_check_ff,
   output reg full_duplex_ff,
   input wire tx_pending,
   input wire bit_tick,
   input wire tx_start,
   input wire tx_collision,
   input wire tx_late,
   output reg tx_retry_ff,
   output reg tx_skip_ff,
   output reg retry_error_ff,
   output reg defer_abort_ff,
   output reg [9:0] backoff_ff
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg [7:0] low_mark_ff, high_mark_ff, evt_en_ff, latched_ff, accept_ff;
   reg [31:0] ctrl_word_ff;
   reg [31:0] ind_data_ff;
   reg [15:0] ind_raddr_ff, ind_waddr_ff;
   reg [23:0] prev_level_ff;
   reg [4:0] attempts_ff;
   reg [15:0] defer_cnt_ff;
   reg [9:0] lfsr_ff;
   reg [1:0] rx_dv_s_ff, crs_s_ff;
   reg [3:0] rxd_s1_ff, rxd_s2_ff;
   reg [7:0] nxt_latched;
   reg [7:0] nxt_rdata;
   reg [9:0] bo_mask;
   wire wr_hit_any;
   wire [23:0] low_mark_bytes, high_mark_bytes;
   wire loopback, rx_gate;

   function [23:0] mark_bytes;
      input [7:0] thr;
      begin
         mark_bytes = {8'h00, thr, 8'h00} << (`MARK_SHIFT - 8);
      end
   endfunction

   function sel_wr;
      input [8:0] a;
      input [8:0] ofs;
      begin
         sel_wr = host_wr && (a == ofs);
      end
   endfunction

   assign low_mark_bytes = mark_bytes(low_mark_ff);
   assign high_mark_bytes = mark_bytes(high_mark_ff);
   assign wr_hit_any = host_wr;
   assign loopback = ctrl_word_ff[`CW_LOOPBACK];

   // ----------------------------------------
   // Host writes
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_mark_ff <= `RST_LOW_MARK;
         high_mark_ff <= `RST_HIGH_MARK;
         evt_en_ff <= `RST_BYTE;
         accept_ff <= `RST_BYTE;
         ctrl_word_ff <= `RST_CTRL_WORD;
         ind_data_ff <= `RST_CTRL_WORD;
         ind_raddr_ff <= 16'h0000;
         ind_waddr_ff <= 16'h0000;
      end else begin
         if (sel_wr(host_addr, `OFS_LOW_MARK))
            low_mark_ff <= host_wdata;
         if (sel_wr(host_addr, `OFS_HIGH_MARK))
            high_mark_ff <= host_wdata;
         if (sel_wr(host_addr, `OFS_EVT_EN))
            evt_en_ff <= {4'h0, host_wdata[3:0]};
         if (sel_wr(host_addr, `OFS_ACCEPT))
            accept_ff <= {1'b0, host_wdata[6:0]};
         if (wr_hit_any && host_addr[8:2] == `OFS_IND_DATA0 >> 2)
            ind_data_ff[8*(3-host_addr[1:0]) +: 8] <= host_wdata;
         if (sel_wr(host_addr, `OFS_IND_RADDR_HI))
            ind_raddr_ff[15:8] <= host_wdata;
         // Low byte write launches the indirect read
         if (sel_wr(host_addr, `OFS_IND_RADDR_LO)) begin
            ind_raddr_ff[7:0] <= host_wdata;
            if ({ind_raddr_ff[15:8], host_wdata} == `IND_CTRL_WORD)
               ind_data_ff <= ctrl_word_ff;
            else
               ind_data_ff <= 32'h00000000;
         end
         if (sel_wr(host_addr, `OFS_IND_WADDR_HI))
            ind_waddr_ff[15:8] <= host_wdata;
         // Low byte write commits the staged word
         if (sel_wr(host_addr, `OFS_IND_WADDR_LO)) begin
            ind_waddr_ff[7:0] <= host_wdata;
            if ({ind_waddr_ff[15:8], host_wdata} == `IND_CTRL_WORD)
               ctrl_word_ff <= ind_data_ff;
         end
      end
   end

   // ----------------------------------------
   // Event latching
   // ----------------------------------------
   always @* begin
      nxt_latched = latched_ff;
      // Clear first so a same-cycle event still wins
      if (host_rd && host_addr == `OFS_EVT_LATCHED)
         nxt_latched = 8'h00;
      if (fifo_overflow)
         nxt_latched[`LS_FIFO_OVF] = 1'b1;
      if (queue_overflow)
         nxt_latched[`LS_QUEUE_OVF] = 1'b1;
      if (prev_level_ff < high_mark_bytes && queue_level >= high_mark_bytes)
         nxt_latched[`LS_HIGH_MARK] = 1'b1;
      if (prev_level_ff >= low_mark_bytes && queue_level < low_mark_bytes)
         nxt_latched[`LS_LOW_MARK] = 1'b1;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_ff <= `RST_BYTE;
         prev_level_ff <= 24'h000000;
         irq_ff <= 1'b0;
      end else begin
         latched_ff <= nxt_latched;
         prev_level_ff <= queue_level;
         // Enable bits 1:0 sit swapped against status bits 1:0
         irq_ff <= (nxt_latched[`LS_FIFO_OVF] & evt_en_ff[`EN_FIFO_OVF]) |
            (nxt_latched[`LS_QUEUE_OVF] & evt_en_ff[`EN_QUEUE_OVF]) |
            (nxt_latched[`LS_HIGH_MARK] & evt_en_ff[`EN_HIGH_MARK]) |
            (nxt_latched[`LS_LOW_MARK] & evt_en_ff[`EN_LOW_MARK]);
      end
   end

   // ----------------------------------------
   // Host reads
   // ----------------------------------------
   always @* begin
      case (host_addr)
         `OFS_LOW_MARK: nxt_rdata = low_mark_ff;
         `OFS_HIGH_MARK: nxt_rdata = high_mark_ff;
         `OFS_EVT_EN: nxt_rdata = evt_en_ff;
         `OFS_EVT_LATCHED: nxt_rdata = latched_ff;
         `OFS_ACCEPT: nxt_rdata = accept_ff;
         `OFS_IND_RADDR_HI: nxt_rdata = ind_raddr_ff[15:8];
         `OFS_IND_RADDR_LO: nxt_rdata = ind_raddr_ff[7:0];
         `OFS_IND_WADDR_HI: nxt_rdata = ind_waddr_ff[15:8];
         `OFS_IND_WADDR_LO: nxt_rdata = ind_waddr_ff[7:0];
         default: begin
            if (host_addr[8:2] == `OFS_IND_DATA0 >> 2)
               nxt_rdata = ind_data_ff[8*(3-host_addr[1:0]) +: 8];
            else
               nxt_rdata = 8'h00;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         host_rdata_ff <= 8'h00;
      else if (host_rd)
         host_rdata_ff <= nxt_rdata;
   end

   // ----------------------------------------
   // PHY pins and loopback
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_dv_s_ff <= 2'b00;
         crs_s_ff <= 2'b00;
         rxd_s1_ff <= 4'h0;
         rxd_s2_ff <= 4'h0;
      end else begin
         rx_dv_s_ff <= {rx_dv_s_ff[0], phy_rx_dv};
         crs_s_ff <= {crs_s_ff[0], phy_crs};
         rxd_s1_ff <= phy_rxd;
         rxd_s2_ff <= rxd_s1_ff;
      end
   end

   // Own frames are dropped in either duplex mode, only when bit 23 asks
   assign rx_gate = ctrl_word_ff[`CW_RX_ALLOW] &
      ~(ctrl_word_ff[`CW_NO_SELF_RX] & tx_en_in);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phy_tx_en_ff <= 1'b0;
         phy_txd_ff <= 4'h0;
         rx_dv_ff <= 1'b0;
         rxd_ff <= 4'h0;
         heartbeat_check_ff <= 1'b0;
         full_duplex_ff <= 1'b0;
      end else begin
         phy_tx_en_ff <= tx_en_in & ctrl_word_ff[`CW_TX_ALLOW] &
            ~loopback;
         phy_txd_ff <= loopback ? 4'h0 : txd_in;
         if (loopback) begin
            rx_dv_ff <= tx_en_in & ctrl_word_ff[`CW_TX_ALLOW] &
               ctrl_word_ff[`CW_RX_ALLOW];
            rxd_ff <= txd_in;
         end else begin
            rx_dv_ff <= rx_dv_s_ff[1] & rx_gate;
            rxd_ff <= rxd_s2_ff;
         end
         heartbeat_check_ff <= ~ctrl_word_ff[`CW_HEARTBEAT_OFF] &
            ~ctrl_word_ff[`CW_FULL_DUPLEX];
         full_duplex_ff <= ctrl_word_ff[`CW_FULL_DUPLEX];
      end
   end

   // ----------------------------------------
   // Collision retry and back-off
   // ----------------------------------------
   always @* begin
      case (ctrl_word_ff[`CW_BACKOFF_HI:`CW_BACKOFF_LO])
         2'b00: bo_mask = 10'h3ff;
         2'b01: bo_mask = 10'h0ff;
         2'b10: bo_mask = 10'h00f;
         default: bo_mask = 10'h001;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         attempts_ff <= 5'd0;
         tx_retry_ff <= 1'b0;
         tx_skip_ff <= 1'b0;
         retry_error_ff <= 1'b0;
         backoff_ff <= 10'h000;
         lfsr_ff <= `LFSR_SEED;
      end else begin
         lfsr_ff <= {lfsr_ff[8:0], lfsr_ff[9] ^ lfsr_ff[6]};
         tx_retry_ff <= 1'b0;
         tx_skip_ff <= 1'b0;
         retry_error_ff <= 1'b0;
         if (tx_start)
            attempts_ff <= 5'd0;
         else if (tx_collision) begin
            if (ctrl_word_ff[`CW_SINGLE_ATTEMPT] ||
               (tx_late && !ctrl_word_ff[`CW_LATE_RETRY])) begin
               tx_skip_ff <= 1'b1;
               attempts_ff <= 5'd0;
            end else if (attempts_ff == `RETRY_LIMIT - 5'd1) begin
               retry_error_ff <= 1'b1;
               attempts_ff <= 5'd0;
            end else begin
               tx_retry_ff <= 1'b1;
               attempts_ff <= attempts_ff + 5'd1;
               backoff_ff <= lfsr_ff & bo_mask;
            end
         end
      end
   end

   // ----------------------------------------
   // Deferral watchdog
   // ----------------------------------------
   // Counts bit times only while carrier holds off a waiting frame
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         defer_cnt_ff <= 16'h0000;
         defer_abort_ff <= 1'b0;
      end else begin
         defer_abort_ff <= 1'b0;
         if (!tx_pending || !crs_s_ff[1] || tx_collision)
            defer_cnt_ff <= 16'h0000;
         else if (bit_tick) begin
            if (defer_cnt_ff == DEFER_LIMIT[15:0]) begin
               defer_abort_ff <= ctrl_word_ff[`CW_DEFER_ABORT];
               defer_cnt_ff <= 16'h0000;
            end else
               defer_cnt_ff <= defer_cnt_ff + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Frame acceptance
   // ----------------------------------------
   rx_frame_filter u_filter (
      .clk(clk),
      .rst_n(rst_n),
      .policy(accept_ff),
      .pad_strip_on(ctrl_word_ff[`CW_PAD_STRIP]),
      .frame_done(frame_done),
      .is_ctrl(is_ctrl),
      .is_pause(is_pause),
      .len_mismatch(len_mismatch),
      .crc_err(crc_err),
      .phy_err(phy_err),
      .dribble(dribble),
      .collided(collided),
      .runt(runt),
      .broadcast(broadcast),
      .frame_len(frame_len),
      .keep_ff(frame_keep),
      .drop_ff(frame_drop),
      .strip_ff(frame_strip)
   );
endmodule // mac_control_rx_filter
`default_nettype wire

// >>> hdl/mac_ctl_defs.vh
`ifndef MAC_CTL_DEFS_VH
`define MAC_CTL_DEFS_VH
// ----------------------------------------
// Host register offsets
// ----------------------------------------
`define OFS_LOW_MARK 9'h15a
`define OFS_HIGH_MARK 9'h15b
`define OFS_EVT_EN 9'h15c
`define OFS_EVT_LATCHED 9'h15d
`define OFS_ACCEPT 9'h15e
`define OFS_IND_DATA0 9'h140
`define OFS_IND_RADDR_HI 9'h144
`define OFS_IND_RADDR_LO 9'h145
`define OFS_IND_WADDR_HI 9'h146
`define OFS_IND_WADDR_LO 9'h147
`define IND_CTRL_WORD 16'h0000
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_LOW_MARK 8'h37
`define RST_HIGH_MARK 8'h3a
`define RST_BYTE 8'h00
`define RST_CTRL_WORD 32'h00000000
// ----------------------------------------
// Event bits
// ----------------------------------------
`define EN_FIFO_OVF 3
`define EN_QUEUE_OVF 2
`define EN_LOW_MARK 1
`define EN_HIGH_MARK 0
`define LS_FIFO_OVF 3
`define LS_QUEUE_OVF 2
`define LS_HIGH_MARK 1
`define LS_LOW_MARK 0
// ----------------------------------------
// Accept policy bits
// ----------------------------------------
`define AP_NONPAUSE 6
`define AP_CTRL 5
`define AP_LEN 4
`define AP_CRC 3
`define AP_DRIBBLE 2
`define AP_PHY_ERR 1
`define AP_BCAST 0
// ----------------------------------------
// Control word bits
// ----------------------------------------
`define CW_HEARTBEAT_OFF 28
`define CW_PORT_SELECT 27
`define CW_NO_SELF_RX 23
`define CW_LOOPBACK 21
`define CW_FULL_DUPLEX 20
`define CW_LATE_RETRY 12
`define CW_SINGLE_ATTEMPT 10
`define CW_PAD_STRIP 8
`define CW_BACKOFF_HI 7
`define CW_BACKOFF_LO 6
`define CW_DEFER_ABORT 5
`define CW_TX_ALLOW 3
`define CW_RX_ALLOW 2
// ----------------------------------------
// Counts
// ----------------------------------------
`define MARK_SHIFT 16
`define MIN_PAYLOAD 14'd46
`define RETRY_LIMIT 5'd16
`define DEFER_BIT_TIMES 24288
`define LFSR_SEED 10'h2a5
`endif

// >>> hdl/rx_frame_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctl_defs.vh"
module rx_frame_filter (
   input wire clk,
   input wire rst_n,
   input wire [7:0] policy,
   input wire pad_strip_on,
   input wire frame_done,
   input wire is_ctrl,
   input wire is_pause,
   input wire len_mismatch,
   input wire crc_err,
   input wire phy_err,
   input wire dribble,
   input wire collided,
   input wire runt,
   input wire broadcast,
   input wire [13:0] frame_len,
   output reg keep_ff,
   output reg drop_ff,
   output reg strip_ff
);
   reg reject;
   always @* begin
      reject = 1'b0;
      if (is_ctrl && !policy[`AP_CTRL])
         reject = 1'b1;
      if (is_ctrl && !is_pause && !policy[`AP_NONPAUSE])
         reject = 1'b1;
      if (len_mismatch && !policy[`AP_LEN])
         reject = 1'b1;
      if ((crc_err || phy_err) && !policy[`AP_CRC])
         reject = 1'b1;
      // Dribble flag is meaningless on collided or runt frames
      if (dribble && !collided && !runt && !policy[`AP_DRIBBLE])
         reject = 1'b1;
      if (phy_err && !policy[`AP_PHY_ERR])
         reject = 1'b1;
      if (broadcast && !policy[`AP_BCAST])
         reject = 1'b1;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         keep_ff <= 1'b0;
         drop_ff <= 1'b0;
         strip_ff <= 1'b0;
      end else begin
         keep_ff <= frame_done & ~reject;
         drop_ff <= frame_done & reject;
         strip_ff <= frame_done & ~reject & pad_strip_on &
            (frame_len < `MIN_PAYLOAD);
      end
   end
endmodule // rx_frame_filter
`default_nettype wire

// >>> verif/mac_ctl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctl_defs.vh"
// ------
// Checker
// ------
module mac_ctl_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [8:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic irq_ff,
   input wire logic fifo_overflow,
   input wire logic queue_overflow,
   input wire logic [23:0] queue_level,
   input wire logic frame_done,
   input wire logic frame_keep,
   input wire logic frame_drop,
   input wire logic frame_strip,
   input wire logic tx_en_in,
   input wire logic [3:0] txd_in,
   input wire logic phy_tx_en_ff,
   input wire logic [3:0] phy_txd_ff,
   input wire logic heartbeat_check_ff,
   input wire logic full_duplex_ff,
   input wire logic tx_pending,
   input wire logic tx_collision,
   input wire logic tx_retry_ff,
   input wire logic tx_skip_ff,
   input wire logic retry_error_ff,
   input wire logic defer_abort_ff,
   input wire logic [9:0] backoff_ff
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   keep_or_drop_a: assert property (frame_done |=> frame_keep != frame_drop)
      else $error("frame not judged exactly once");
   strip_kept_a: assert property (frame_strip |-> frame_keep)
      else $error("strip on a dropped frame");
   irq_cause_a: assert property ($rose(irq_ff) |->
      $past(fifo_overflow | queue_overflow | host_wr) ||
      $past(queue_level) != $past(queue_level, 2))
      else $error("interrupt rose without a cause");
   irq_read_clear_a: assert property (host_rd &&
      host_addr == `OFS_EVT_LATCHED && !fifo_overflow && !queue_overflow &&
      queue_level == $past(queue_level) |=> !irq_ff)
      else $error("interrupt stayed after status read");
   tx_gate_a: assert property (phy_tx_en_ff |-> $past(tx_en_in))
      else $error("transmit enable without request");
   tx_data_a: assert property (phy_tx_en_ff |-> phy_txd_ff == $past(txd_in))
      else $error("transmit nibble differs");
   retry_one_a: assert property ((tx_retry_ff | tx_skip_ff | retry_error_ff)
      |-> $past(tx_collision) &&
      $onehot0({tx_retry_ff, tx_skip_ff, retry_error_ff}))
      else $error("retry outcome without collision");
   backoff_hold_a: assert property (!tx_retry_ff |-> $stable(backoff_ff))
      else $error("backoff changed without retry");
   duplex_hb_a: assert property (full_duplex_ff |-> !heartbeat_check_ff)
      else $error("heartbeat active in full duplex");
   defer_cause_a: assert property (defer_abort_ff |-> $past(tx_pending))
      else $error("deferral abort without pending frame");
   cover property (frame_strip);
   cover property ($rose(irq_ff));
   cover property (retry_error_ff);
   cover property (defer_abort_ff);
endmodule // mac_ctl_checker
bind mac_control_rx_filter mac_ctl_checker mac_ctl_checker_i (
   .clk, .rst_n, .host_addr, .host_wr, .host_rd, .irq_ff, .fifo_overflow,
   .queue_overflow, .queue_level, .frame_done, .frame_keep, .frame_drop,
   .frame_strip, .tx_en_in, .txd_in, .phy_tx_en_ff, .phy_txd_ff,
   .heartbeat_check_ff, .full_duplex_ff, .tx_pending, .tx_collision,
   .tx_retry_ff, .tx_skip_ff, .retry_error_ff, .defer_abort_ff,
   .backoff_ff);
`default_nettype wire

// >>> verif/phy_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// PHY side
// ------
module phy_model (
   input wire logic clk,
   input wire logic send,
   input wire logic crs_req,
   output logic phy_rx_dv,
   output logic [3:0] phy_rxd,
   output logic phy_crs
);
   logic [3:0] cnt = 4'h0;
   initial phy_rxd = 4'h0;
   // Idle data shows the inverse, never a stale nibble
   always @(posedge clk) begin
      cnt <= cnt + 4'h1;
      phy_rx_dv <= send;
      phy_rxd <= send ? cnt : ~phy_rxd;
      phy_crs <= send | crs_req;
   end
endmodule // phy_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctl_defs.vh"
// ------
// Bench
// ------
module testbench;
   logic clk, rst_n, host_wr, host_rd, fifo_overflow, queue_overflow;
   logic frame_done, tx_en_in, tx_pending, bit_tick, tx_start;
   logic tx_collision, tx_late, send, crs_req;
   logic [8:0] host_addr, fl;
   logic [7:0] host_wdata;
   logic [23:0] queue_level;
   logic [13:0] frame_len;
   logic [3:0] txd_in;
   wire [7:0] host_rdata_ff;
   wire [9:0] backoff_ff;
   wire [3:0] phy_txd_ff, rxd_ff, phy_rxd;
   wire irq_ff, frame_keep, frame_drop, frame_strip, phy_tx_en_ff;
   wire phy_rx_dv, phy_crs, rx_dv_ff, heartbeat_check_ff, full_duplex_ff;
   wire tx_retry_ff, tx_skip_ff, retry_error_ff, defer_abort_ff;
   int err_total = 0;
   int n_compared = 0;
   int n;
   int sh [4] = '{10, 8, 4, 1};
   mac_control_rx_filter #(.DEFER_LIMIT(20)) mac_control_rx_filter_i (
      .clk, .rst_n, .host_addr, .host_wr, .host_rd, .host_wdata,
      .host_rdata_ff, .irq_ff, .fifo_overflow, .queue_overflow,
      .queue_level, .frame_done, .is_ctrl(fl[8]), .is_pause(fl[7]),
      .len_mismatch(fl[6]), .crc_err(fl[5]), .phy_err(fl[4]),
      .dribble(fl[3]), .collided(fl[2]), .runt(fl[1]), .broadcast(fl[0]),
      .frame_len, .frame_keep, .frame_drop, .frame_strip, .tx_en_in,
      .txd_in, .phy_tx_en_ff, .phy_txd_ff, .phy_rx_dv, .phy_rxd, .phy_crs,
      .rx_dv_ff, .rxd_ff, .heartbeat_check_ff, .full_duplex_ff,
      .tx_pending, .bit_tick, .tx_start, .tx_collision, .tx_late,
      .tx_retry_ff, .tx_skip_ff, .retry_error_ff, .defer_abort_ff,
      .backoff_ff);
   phy_model phy_model_i (.clk, .send, .crs_req, .phy_rx_dv, .phy_rxd,
      .phy_crs);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One idle cycle after each strobe keeps drivers race free
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      cyc(1);
      host_wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
      host_addr = a;
      host_rd = 1'b1;
      cyc(1);
      host_rd = 1'b0;
      cyc(1);
      chk_val(10'(host_rdata_ff), 10'(e));
   endtask
   task automatic ind_wr(input logic [31:0] d,
      input logic [15:0] ia = `IND_CTRL_WORD);
      for (int i = 0; i < 4; i++)
         wr(`OFS_IND_DATA0 + 9'(i), d[31-8*i -: 8]);
      wr(`OFS_IND_WADDR_HI, ia[15:8]);
      wr(`OFS_IND_WADDR_LO, ia[7:0]);
   endtask
   task automatic ind_rd(input logic [31:0] e,
      input logic [15:0] ia = `IND_CTRL_WORD);
      wr(`OFS_IND_RADDR_HI, ia[15:8]);
      wr(`OFS_IND_RADDR_LO, ia[7:0]);
      cyc(1);
      for (int i = 0; i < 4; i++)
         rd_chk(`OFS_IND_DATA0 + 9'(i), e[31-8*i -: 8]);
   endtask
   task automatic evt(input logic [1:0] e);
      {fifo_overflow, queue_overflow} = e;
      cyc(1);
      {fifo_overflow, queue_overflow} = 2'b00;
      cyc(1);
   endtask
   task automatic lvl(input logic [23:0] q, input logic [7:0] e, input logic i);
      queue_level = q;
      cyc(2);
      chk_val(10'(irq_ff), 10'(i));
      rd_chk(`OFS_EVT_LATCHED, e);
   endtask
   task automatic frame(input logic [8:0] f, input logic [1:0] e,
      input logic [13:0] len = 14'd64);
      fl = f;
      frame_len = len;
      frame_done = 1'b1;
      cyc(1);
      frame_done = 1'b0;
      fl = ~f;
      chk_val(10'({frame_keep, frame_drop, frame_strip}),
         10'({e[1], ~e[1], e[0]}));
      cyc(1);
   endtask
   task automatic col(input logic late, input logic [2:0] e);
      tx_collision = 1'b1;
      tx_late = late;
      cyc(1);
      tx_collision = 1'b0;
      chk_val(10'({tx_retry_ff, tx_skip_ff, retry_error_ff}), 10'(e));
      cyc(1);
   endtask
   task automatic start;
      tx_start = 1'b1;
      cyc(1);
      tx_start = 1'b0;
      cyc(1);
   endtask
   initial begin
      {host_wr, host_rd, fifo_overflow, queue_overflow, frame_done} = 5'h00;
      {tx_en_in, tx_pending, bit_tick, tx_start, tx_collision} = 5'h00;
      {tx_late, send, crs_req} = 3'h0;
      {host_addr, fl, host_wdata, queue_level} = 50'h0;
      frame_len = 14'h0;
      txd_in = 4'h0;
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      rd_chk(`OFS_EVT_EN, 8'h00);
      rd_chk(`OFS_ACCEPT, 8'h00);
      rd_chk(`OFS_LOW_MARK, 8'h37);
      rd_chk(`OFS_HIGH_MARK, 8'h3a);
      rd_chk(9'h1ff, 8'h00);
      ind_rd(32'h0);
      wr(`OFS_EVT_EN, 8'h0f);
      evt(2'b10);
      chk_val(10'(irq_ff), 10'h1);
      rd_chk(`OFS_EVT_LATCHED, 8'h08);
      chk_val(10'(irq_ff), 10'h0);
      wr(`OFS_EVT_EN, 8'h00);
      evt(2'b01);
      chk_val(10'(irq_ff), 10'h0);
      rd_chk(`OFS_EVT_LATCHED, 8'h04);
      rd_chk(`OFS_EVT_LATCHED, 8'h00);
      wr(`OFS_LOW_MARK, 8'h01);
      wr(`OFS_HIGH_MARK, 8'h02);
      wr(`OFS_EVT_EN, 8'h02);
      lvl(24'h01ffff, 8'h00, 1'b0);
      lvl(24'h020000, 8'h02, 1'b0);
      lvl(24'h010000, 8'h00, 1'b0);
      lvl(24'h00ffff, 8'h01, 1'b1);
      chk_val(10'(irq_ff), 10'h0);
      frame(9'h000, 2'b10);
      frame(9'h001, 2'b00);
      frame(9'h180, 2'b00);
      frame(9'h040, 2'b00);
      frame(9'h020, 2'b00);
      frame(9'h010, 2'b00);
      frame(9'h008, 2'b00);
      frame(9'h00c, 2'b10);
      frame(9'h00a, 2'b10);
      wr(`OFS_ACCEPT, 8'h20);
      frame(9'h180, 2'b10);
      frame(9'h100, 2'b00);
      wr(`OFS_ACCEPT, 8'h60);
      frame(9'h100, 2'b10);
      wr(`OFS_ACCEPT, 8'h08);
      frame(9'h020, 2'b10);
      frame(9'h010, 2'b00);
      wr(`OFS_ACCEPT, 8'h02);
      frame(9'h010, 2'b00);
      wr(`OFS_ACCEPT, 8'h0a);
      frame(9'h010, 2'b10);
      wr(`OFS_ACCEPT, 8'hff);
      rd_chk(`OFS_ACCEPT, 8'h7f);
      frame(9'h17f, 2'b10);
      ind_wr(32'h00000100);
      frame(9'h000, 2'b11, 14'd45);
      frame(9'h000, 2'b10, 14'd46);
      ind_wr(32'h0010000c);
      ind_wr(32'hffffffff, 16'h0001);
      ind_rd(32'h0010000c);
      ind_rd(32'h0, 16'h0001);
      chk_val(10'({full_duplex_ff, heartbeat_check_ff}), 10'h2);
      ind_wr(32'h1000000c);
      chk_val(10'(heartbeat_check_ff), 10'h0);
      tx_en_in = 1'b1;
      txd_in = 4'ha;
      send = 1'b1;
      ind_wr(32'h0000000c);
      chk_val(10'({heartbeat_check_ff, phy_tx_en_ff, phy_txd_ff}), 10'h3a);
      chk_val(10'(rx_dv_ff), 10'h1);
      ind_wr(32'h0080000c);
      chk_val(10'(rx_dv_ff), 10'h0);
      ind_wr(32'h00000004);
      chk_val(10'({phy_tx_en_ff, rx_dv_ff}), 10'h1);
      ind_wr(32'h00000008);
      chk_val(10'(rx_dv_ff), 10'h0);
      send = 1'b0;
      ind_wr(32'h0020000c);
      chk_val(10'({phy_tx_en_ff, rx_dv_ff, rxd_ff}), 10'h1a);
      tx_en_in = 1'b0;
      ind_wr(32'h0000008c);
      start;
      for (int i = 1; i <= 16; i++) begin
         col(1'b0, (i < 16) ? 3'b100 : 3'b001);
         chk_val(backoff_ff >> 4, 10'h0);
      end
      for (int k = 0; k < 4; k++) begin
         ind_wr(32'h0c | (k << 6));
         start;
         col(1'b0, 3'b100);
         chk_val(backoff_ff >> sh[k], 10'h0);
      end
      ind_wr(32'h0000040c);
      col(1'b0, 3'b010);
      ind_wr(32'h0000000c);
      start;
      col(1'b1, 3'b010);
      ind_wr(32'h0000100c);
      col(1'b1, 3'b100);
      ind_wr(32'h0000002c);
      {tx_pending, bit_tick, crs_req} = 3'b111;
      n = 0;
      // Bounded poll; running out fails the range check below
      while (defer_abort_ff !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk_val(10'(n >= 20 && n <= 25), 10'h1);
      {tx_pending, crs_req} = 2'b00;
      ind_wr(32'h0000000c);
      {tx_pending, crs_req} = 2'b11;
      n = 0;
      repeat (40) begin
         cyc(1);
         n = n | int'(defer_abort_ff !== 1'b0);
      end
      chk_val(10'(n), 10'h0);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      rd_chk(`OFS_ACCEPT, 8'h00);
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
